// ---- rtl/ltd_ctrl.sv ----
// Line termination, pulse template and transmit driver enable control
// for four channels, with an AXI4-Lite register slave.
// Assumes loss detectors and the high-impedance pin are asynchronous
// levels; waveform sample addresses come from logic on aclk.
//
// Functional notes
// - -15 dB template scale defaults 001000, 12.5% steps
// - -22.5 dB template scale defaults 000100, 25% steps
// - Hold 16x4 seven-bit pulse samples per template
// - Transmit termination: internal 75/100/110/120 or external
// - Pin or channel bit turns driver off
// - Transmit circuitry keeps running while driver off, except in power-down
// - Master clock loss turns all drivers off
// - Transmit clock loss off, except loopback/internal pattern
// - Drivers off after soft, pin or power reset
// - Transmit power-down turns path and driver off
// - Receive termination: internal 75/100/110/120 or external
module ltd_ctrl
    import ltd_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic                    ce,
    // AXI4-Lite write address
    input  wire logic [31:0]             s_axi_awaddr,
    input  wire logic [2:0]              s_axi_awprot,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [31:0]             s_axi_araddr,
    input  wire logic [2:0]              s_axi_arprot,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    // Asynchronous line-side conditions
    input  wire logic                    hz_pin,
    input  wire logic                    master_clock_lost,
    input  wire logic [NCH-1:0]          channel_tx_clock_lost,
    // Waveform sample address from the shaper
    input  wire logic [NCH-1:0][1:0]     wave_ui,
    input  wire logic [NCH-1:0][3:0]     wave_sample,
    // Line-side controls
    output logic [NCH-1:0]               tx_line_pair_drive_en,
    output logic [NCH-1:0]               tx_path_on,
    output logic [NCH-1:0]               tx_int_match_en,
    output logic [NCH-1:0][1:0]          tx_term_sel,
    output logic [NCH-1:0]               rx_int_match_en,
    output logic [NCH-1:0][1:0]          rx_term_sel,
    output logic [NCH-1:0][3:0]          pulse_template_select,
    output logic [NCH-1:0][5:0]          amplitude_scale,
    output logic [NCH-1:0][7:0]          scale_step_tenths,
    output logic [NCH-1:0][6:0]          wave_code
);

    typedef struct packed {
        logic                 aw_got;
        logic                 w_got;
        logic [8:0]           awaddr;
        logic [7:0]           wdata;
        logic                 wstrb0;
        logic                 awready;
        logic                 wready;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 arready;
        logic                 rvalid;
        logic [1:0]           rresp;
        logic [7:0]           rdata;
        logic [NCH-1:0][7:0]  cfg0;
        logic [NCH-1:0][7:0]  cfg1;
        logic [NCH-1:0][7:0]  term;
        logic [NCH-1:0][5:0]  scale;
        logic [4:0]           hold_cnt;
        logic                 pin_s1;
        logic                 pin_s2;
        logic                 mclk_s1;
        logic                 mclk_s2;
        logic [NCH-1:0]       tclk_s1;
        logic [NCH-1:0]       tclk_s2;
        logic [NCH-1:0]       drive_en;
        logic [NCH-1:0][6:0]  wave;
        logic [NCH-1:0][7:0]  step;
    } ltd_state_t;

    ltd_state_t r_reg;
    ltd_state_t r_next;

    logic [NCH-1:0]       drive_ok;
    logic [NCH-1:0][6:0]  wave_lookup;
    logic [NCH-1:0][7:0]  step_lookup;
    logic [NCH-1:0][7:0]  status_word;

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_ch
            logic       tclk_loss_eff;
            logic [5:0] rom_idx;
            logic [3:0] sel;

            assign sel = r_reg.cfg1[ch][3:0];
            assign rom_idx = {wave_ui[ch], wave_sample[ch]};
            // Loopback and internal pattern run from the master clock
            assign tclk_loss_eff = r_reg.tclk_s2[ch]
                & ~(r_reg.cfg0[ch][RLB_BIT] | r_reg.cfg0[ch][IPAT_BIT]);
            assign drive_ok[ch] = ~(r_reg.pin_s2
                | r_reg.cfg1[ch][THZ_BIT]
                | r_reg.mclk_s2
                | tclk_loss_eff
                | r_reg.cfg0[ch][TX_OFF_BIT]
                | (r_reg.hold_cnt != 5'h00));
            assign wave_lookup[ch] =
                (sel == PULSE_LBO15) ? TPL15[rom_idx] :
                (sel == PULSE_LBO22) ? TPL22[rom_idx] : 7'h00;
            assign step_lookup[ch] =
                (sel == PULSE_LBO15) ? STEP_LBO15 :
                (sel == PULSE_LBO22) ? STEP_LBO22 : 8'h00;
            assign status_word[ch] = {3'h0, (r_reg.hold_cnt != 5'h00),
                r_reg.pin_s2, r_reg.tclk_s2[ch], r_reg.mclk_s2,
                r_reg.drive_en[ch]};

            assign tx_line_pair_drive_en[ch] = r_reg.drive_en[ch];
            // Power-down only, never the high-impedance causes
            assign tx_path_on[ch] = ~r_reg.cfg0[ch][TX_OFF_BIT];
            assign tx_int_match_en[ch] = ~r_reg.term[ch][TERM_EXT_BIT];
            assign tx_term_sel[ch] = r_reg.term[ch][1:0];
            assign rx_int_match_en[ch] =
                ~r_reg.term[ch][RTERM_LSB+TERM_EXT_BIT];
            assign rx_term_sel[ch] =
                r_reg.term[ch][RTERM_LSB+1:RTERM_LSB];
            assign pulse_template_select[ch] = r_reg.cfg1[ch][3:0];
            assign amplitude_scale[ch] = r_reg.scale[ch];
            assign scale_step_tenths[ch] = r_reg.step[ch];
            assign wave_code[ch] = r_reg.wave[ch];
        end
    endgenerate

    assign s_axi_awready = r_reg.awready;
    assign s_axi_wready  = r_reg.wready;
    assign s_axi_bvalid  = r_reg.bvalid;
    assign s_axi_bresp   = r_reg.bresp;
    assign s_axi_arready = r_reg.arready;
    assign s_axi_rvalid  = r_reg.rvalid;
    assign s_axi_rresp   = r_reg.rresp;
    assign s_axi_rdata   = {24'h00_0000, r_reg.rdata};

    always_comb begin
        logic [1:0] wch;
        logic [4:0] widx;
        logic [1:0] rch;
        logic [4:0] ridx;
        wch = 2'h0;
        widx = 5'h00;
        rch = s_axi_araddr[8:7];
        ridx = s_axi_araddr[6:2];
        r_next = r_reg;

        // Two-stage synchronisers
        r_next.pin_s1  = hz_pin;
        r_next.pin_s2  = r_reg.pin_s1;
        r_next.mclk_s1 = master_clock_lost;
        r_next.mclk_s2 = r_reg.mclk_s1;
        r_next.tclk_s1 = channel_tx_clock_lost;
        r_next.tclk_s2 = r_reg.tclk_s1;

        if (r_reg.hold_cnt != 5'h00) begin
            r_next.hold_cnt = r_reg.hold_cnt - 5'h01;
        end

        r_next.drive_en = drive_ok;
        r_next.wave = wave_lookup;
        r_next.step = step_lookup;

        // Write channels, taken in either order
        if (r_reg.bvalid && s_axi_bready) begin
            r_next.bvalid = 1'b0;
        end
        if (s_axi_awvalid && r_reg.awready) begin
            r_next.aw_got = 1'b1;
            r_next.awaddr = s_axi_awaddr[8:0];
        end
        if (s_axi_wvalid && r_reg.wready) begin
            r_next.w_got  = 1'b1;
            r_next.wdata  = s_axi_wdata[7:0];
            r_next.wstrb0 = s_axi_wstrb[0];
        end

        if (r_next.aw_got && r_next.w_got && !r_next.bvalid) begin
            wch = r_next.awaddr[8:7];
            widx = r_next.awaddr[6:2];
            r_next.aw_got = 1'b0;
            r_next.w_got  = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp  = RESP_OKAY;
            if (r_next.awaddr[1:0] != 2'h0) begin
                r_next.bresp = RESP_SLVERR;
            end else begin
                unique case (widx)
                    IDX_TX_CFG0: begin
                        if (r_next.wstrb0) begin
                            r_next.cfg0[wch] = r_next.wdata;
                        end
                    end
                    IDX_TX_CFG1: begin
                        if (r_next.wstrb0) begin
                            r_next.cfg1[wch] = r_next.wdata;
                            if (r_next.wdata[3:0] == PULSE_LBO15) begin
                                r_next.scale[wch] = SCALE_DEF15;
                            end else if (r_next.wdata[3:0] == PULSE_LBO22)
                            begin
                                r_next.scale[wch] = SCALE_DEF22;
                            end
                        end
                    end
                    IDX_SCALE: begin
                        if (r_next.wstrb0) begin
                            r_next.scale[wch] = r_next.wdata[5:0];
                        end
                    end
                    IDX_TERM: begin
                        if (r_next.wstrb0) begin
                            r_next.term[wch] = r_next.wdata;
                        end
                    end
                    IDX_SOFT_RST: begin
                        if (r_next.wstrb0 && r_next.wdata[0]) begin
                            for (int i = 0; i < NCH; i++) begin
                                r_next.cfg0[i]  = TX_CFG0_RST;
                                r_next.cfg1[i]  = TX_CFG1_RST;
                                r_next.term[i]  = TERM_RST;
                                r_next.scale[i] = SCALE_RST;
                            end
                            r_next.hold_cnt = HOLD_CYCLES;
                            r_next.drive_en = '0;
                        end
                    end
                    IDX_STATUS: begin
                        r_next.bresp = RESP_OKAY;
                    end
                    default: begin
                        r_next.bresp = RESP_SLVERR;
                    end
                endcase
            end
        end
        r_next.awready = !r_next.aw_got && !r_next.bvalid;
        r_next.wready  = !r_next.w_got && !r_next.bvalid;

        // Read channel
        if (r_reg.rvalid && s_axi_rready) begin
            r_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && r_reg.arready) begin
            r_next.rvalid = 1'b1;
            r_next.rresp  = RESP_OKAY;
            r_next.rdata  = 8'h00;
            if (s_axi_araddr[1:0] != 2'h0) begin
                r_next.rresp = RESP_SLVERR;
            end else begin
                unique case (ridx)
                    IDX_TX_CFG0:  r_next.rdata = r_reg.cfg0[rch];
                    IDX_TX_CFG1:  r_next.rdata = r_reg.cfg1[rch];
                    IDX_SCALE:    r_next.rdata = {2'h0, r_reg.scale[rch]};
                    IDX_TERM:     r_next.rdata = r_reg.term[rch];
                    IDX_SOFT_RST: r_next.rdata = 8'h00;
                    IDX_STATUS:   r_next.rdata = status_word[rch];
                    default:      r_next.rresp = RESP_SLVERR;
                endcase
            end
        end
        r_next.arready = !r_next.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= '0;
            for (int i = 0; i < NCH; i++) begin
                r_reg.cfg0[i]  <= TX_CFG0_RST;
                r_reg.cfg1[i]  <= TX_CFG1_RST;
                r_reg.term[i]  <= TERM_RST;
                r_reg.scale[i] <= SCALE_RST;
            end
            r_reg.hold_cnt <= HOLD_CYCLES;
            r_reg.awready  <= 1'b1;
            r_reg.wready   <= 1'b1;
            r_reg.arready  <= 1'b1;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

endmodule

// ---- rtl/ltd_pkg.sv ----
// Package for the line termination and driver high-impedance control block.
// Assumes a 50 MHz aclk and register access over AXI4-Lite.
package ltd_pkg;

    localparam int NCH = 4;

    // Register indices, byte address is channel times 128 plus four times the index
    localparam logic [4:0] IDX_TX_CFG0  = 5'h02;
    localparam logic [4:0] IDX_TX_CFG1  = 5'h03;
    localparam logic [4:0] IDX_SCALE    = 5'h04;
    localparam logic [4:0] IDX_SOFT_RST = 5'h06;
    localparam logic [4:0] IDX_TERM     = 5'h1a;
    localparam logic [4:0] IDX_STATUS   = 5'h1f;

    // Field positions
    localparam int TX_OFF_BIT   = 0;
    localparam int RLB_BIT      = 1;
    localparam int IPAT_BIT     = 2;
    localparam int THZ_BIT      = 4;
    localparam int TERM_EXT_BIT = 2;
    localparam int RTERM_LSB    = 3;

    // Reset values
    localparam logic [7:0] TX_CFG0_RST = 8'h00;
    localparam logic [7:0] TX_CFG1_RST = 8'h00;
    localparam logic [7:0] TERM_RST    = 8'h00;
    localparam logic [5:0] SCALE_RST   = 6'h00;

    // Pulse templates and their amplitude scale defaults
    localparam logic [3:0] PULSE_LBO15 = 4'hA;
    localparam logic [3:0] PULSE_LBO22 = 4'hB;
    localparam logic [5:0] SCALE_DEF15 = 6'h08;
    localparam logic [5:0] SCALE_DEF22 = 6'h04;
    // Scale step in tenths of a percent
    localparam logic [7:0] STEP_LBO15  = 8'h7D;
    localparam logic [7:0] STEP_LBO22  = 8'hFA;

    // Cycles the driver stays off after any reset
    localparam logic [4:0] HOLD_CYCLES = 5'h10;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Index is unit interval times sixteen plus sample
    localparam logic [6:0] TPL15 [0:63] = '{
        7'h00, 7'h00, 7'h00, 7'h01, 7'h04, 7'h08, 7'h0E, 7'h14,
        7'h1B, 7'h22, 7'h2A, 7'h30, 7'h35, 7'h37, 7'h38, 7'h37,
        7'h35, 7'h33, 7'h30, 7'h2D, 7'h2A, 7'h27, 7'h24, 7'h21,
        7'h1E, 7'h1C, 7'h1A, 7'h17, 7'h15, 7'h14, 7'h12, 7'h10,
        7'h0F, 7'h0D, 7'h0C, 7'h0B, 7'h0A, 7'h09, 7'h08, 7'h07,
        7'h06, 7'h06, 7'h05, 7'h05, 7'h04, 7'h04, 7'h03, 7'h03,
        7'h03, 7'h02, 7'h02, 7'h02, 7'h02, 7'h01, 7'h01, 7'h01,
        7'h01, 7'h01, 7'h01, 7'h01, 7'h01, 7'h00, 7'h00, 7'h00};

    localparam logic [6:0] TPL22 [0:63] = '{
        7'h01, 7'h03, 7'h05, 7'h08, 7'h0C, 7'h11, 7'h16, 7'h1B,
        7'h21, 7'h26, 7'h2A, 7'h2E, 7'h31, 7'h33, 7'h34, 7'h34,
        7'h35, 7'h35, 7'h34, 7'h33, 7'h32, 7'h30, 7'h2E, 7'h2D,
        7'h2B, 7'h29, 7'h27, 7'h24, 7'h22, 7'h20, 7'h1E, 7'h1C,
        7'h1B, 7'h19, 7'h17, 7'h15, 7'h14, 7'h12, 7'h11, 7'h10,
        7'h0E, 7'h0D, 7'h0C, 7'h0B, 7'h0A, 7'h09, 7'h08, 7'h08,
        7'h07, 7'h06, 7'h06, 7'h05, 7'h05, 7'h05, 7'h04, 7'h04,
        7'h04, 7'h04, 7'h03, 7'h03, 7'h03, 7'h03, 7'h03, 7'h02};

endpackage

// ---- test/ltd_props.sv ----
// Assertion checker for the line driver control block.
// Assumes ce high and write address offered together with write data.
module ltd_props
    import ltd_pkg::*;
(
    // Clock and reset
    input wire logic                 aclk,
    input wire logic                 aresetn,
    // Register bus
    input wire logic [31:0]          s_axi_awaddr,
    input wire logic                 s_axi_awvalid,
    input wire logic                 s_axi_awready,
    input wire logic [31:0]          s_axi_wdata,
    input wire logic [3:0]           s_axi_wstrb,
    input wire logic                 s_axi_wvalid,
    input wire logic                 s_axi_wready,
    input wire logic [1:0]           s_axi_bresp,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_bready,
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire logic [31:0]          s_axi_rdata,
    input wire logic                 s_axi_rvalid,
    input wire logic                 s_axi_rready,
    // Line side
    input wire logic                 hz_pin,
    input wire logic                 master_clock_lost,
    input wire logic [NCH-1:0]       tx_line_pair_drive_en,
    input wire logic [NCH-1:0]       tx_path_on,
    input wire logic [NCH-1:0][5:0]  amplitude_scale,
    input wire logic [NCH-1:0][7:0]  scale_step_tenths
);
    logic       wr_hs;
    logic       wr_do;
    logic [1:0] wr_ch;
    logic [4:0] rel_cnt;

    assign wr_hs = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
    assign wr_do = wr_hs & s_axi_wstrb[0];

    // Cycles since reset release, channel of the last write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rel_cnt <= 5'h00;
        end else if (rel_cnt != 5'h1f) begin
            rel_cnt <= rel_cnt + 5'h01;
        end
        if (wr_hs) begin
            wr_ch <= s_axi_awaddr[8:7];
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_pin_off: assert property (hz_pin[*3] |=>
        tx_line_pair_drive_en == '0) else $error("pin high, driver on");
    chk_mclk_off: assert property (master_clock_lost[*3] |=>
        tx_line_pair_drive_en == '0) else $error("clock lost, driver on");
    chk_drive_cause: assert property (|tx_line_pair_drive_en |->
        !$past(hz_pin, 3) && !$past(master_clock_lost, 3))
        else $error("driver on under an off condition");
    chk_reset_hold: assert property (rel_cnt < 5'h11 |->
        tx_line_pair_drive_en == '0) else $error("driver on after reset");
    chk_thz_bit: assert property (wr_do && s_axi_awaddr[6:0] == 7'h0c
        && s_axi_wdata[4] |=> ##1 !tx_line_pair_drive_en[wr_ch]
        && $stable(tx_path_on)) else $error("channel bit ignored");
    chk_pdown_off: assert property (wr_do && s_axi_awaddr[6:0] == 7'h08
        && s_axi_wdata[0] |=> ##1 !tx_line_pair_drive_en[wr_ch]
        && !tx_path_on[wr_ch]) else $error("power-down ignored");
    chk_scale_fifteen: assert property (wr_do && s_axi_awaddr[8:0] == 9'h00c
        && s_axi_wdata[3:0] == 4'ha |=> ##1 amplitude_scale[0] == 6'h08
        && scale_step_tenths[0] == 8'h7d) else $error("scale default wrong");
    chk_scale_twenty: assert property (wr_do && s_axi_awaddr[8:0] == 9'h00c
        && s_axi_wdata[3:0] == 4'hb |=> ##1 amplitude_scale[0] == 6'h04
        && scale_step_tenths[0] == 8'hfa) else $error("scale default wrong");
    chk_bresp_time: assert property (wr_hs |=> s_axi_bvalid)
        else $error("write response late");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    chk_rresp_time: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read response late");
endmodule

bind ltd_ctrl ltd_props u_props (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .hz_pin, .master_clock_lost,
    .tx_line_pair_drive_en, .tx_path_on, .amplitude_scale, .scale_step_tenths
);

// ---- test/ltd_line_fe.sv ----
// Model of the analog front end's clock loss detectors.
// Assumes the bench commands clock stops; losses are async levels.
module ltd_line_fe
    import ltd_pkg::*;
(
    // Commands from the bench
    input wire logic           mclk_stop,
    input wire logic [NCH-1:0] tclk_stop,
    // Loss detector levels
    output logic               master_clock_lost,
    output logic [NCH-1:0]     channel_tx_clock_lost
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        master_clock_lost = 1'b0;
        channel_tx_clock_lost = '0;
    end
    // Detectors settle a few ns away from any clock edge
    always @(mclk_stop) master_clock_lost <= #7 mclk_stop;
    always @(tclk_stop) channel_tx_clock_lost <= #7 tclk_stop;
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the line driver control block.
// Assumes the checker is bound and the front-end model drives losses.
module testbench;
    import ltd_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic                aclk, aresetn, ce, hz_pin, mclk_stop;
    logic [31:0]         s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [2:0]          s_axi_awprot, s_axi_arprot;
    logic [3:0]          s_axi_wstrb;
    logic [1:0]          s_axi_bresp, s_axi_rresp, rs;
    logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic                s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic                s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic                s_axi_rready, master_clock_lost;
    logic [NCH-1:0]      tclk_stop, channel_tx_clock_lost, tx_path_on;
    logic [NCH-1:0]      tx_line_pair_drive_en, tx_int_match_en, rx_int_match_en;
    logic [NCH-1:0][1:0] wave_ui, tx_term_sel, rx_term_sel;
    logic [NCH-1:0][3:0] wave_sample, pulse_template_select;
    logic [NCH-1:0][5:0] amplitude_scale;
    logic [NCH-1:0][7:0] scale_step_tenths;
    logic [NCH-1:0][6:0] wave_code;
    logic [31:0]         rd;
    int                  errors, tests_run, cycles;

    ltd_ctrl uut (.*);
    ltd_line_fe u_fe (.mclk_stop(mclk_stop), .tclk_stop(tclk_stop),
        .master_clock_lost(master_clock_lost),
        .channel_tx_clock_lost(channel_tx_clock_lost));

    always #10 aclk = ~aclk;

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("Error %0t: run hung", $time);
            tally_and_finish();
        end
    end

    function automatic logic [31:0] ad(input int ch, input logic [4:0] idx);
        return 32'(ch) * 32'h0080 + {25'h0, idx, 2'b00};
    endfunction

    task automatic chk(input logic [31:0] got, exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask

    task automatic axi_wr(input logic [31:0] a, input logic [7:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(negedge aclk);
            aw_ok = aw_ok | (s_axi_awvalid & s_axi_awready);
            w_ok = w_ok | (s_axi_wvalid & s_axi_wready);
            @(posedge aclk);
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end
        @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [31:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(negedge aclk); while (s_axi_arready !== 1'b1);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask

    task automatic set_wave(input logic [1:0] ui, input logic [3:0] s);
        @(posedge aclk);
        wave_ui[0] <= ui;
        wave_sample[0] <= s;
        settle(1);
    endtask

    task automatic t_reset();
        settle(8);
        chk(tx_line_pair_drive_en, 4'h0, "in hold");
        settle(12);
        chk(tx_line_pair_drive_en, 4'hf, "after hold");
        axi_rd(ad(0, IDX_STATUS));
        chk(rd, 32'h1, "status");
        axi_rd(ad(3, IDX_TX_CFG1));
        chk(rd, 32'h0, "cfg one reset");
        axi_rd(ad(0, 5'h05));
        chk(rs, RESP_SLVERR, "unmapped read");
        $display("reset test done");
    endtask

    task automatic t_term();
        for (int v = 0; v < 8; v++) begin
            axi_wr(ad(1, IDX_TERM), 8'(v * 9));
            settle(2);
            chk(tx_int_match_en[1], !v[2], "tx match");
            chk(tx_term_sel[1], v[1:0], "tx select");
            chk(rx_int_match_en[1], !v[2], "rx match");
            chk(rx_term_sel[1], v[1:0], "rx select");
        end
        $display("term test done");
    endtask

    task automatic t_template();
        axi_wr(ad(0, IDX_TERM), 8'h02);
        axi_wr(ad(0, IDX_TX_CFG1), 8'h0a);
        set_wave(2'd0, 4'd15);
        chk(amplitude_scale[0], 6'h08, "scale default");
        chk(scale_step_tenths[0], 8'd125, "scale step");
        chk(wave_code[0], 7'h37, "sample");
        set_wave(2'd1, 4'd0);
        chk(wave_code[0], 7'h35, "sample");
        axi_wr(ad(0, IDX_TX_CFG1), 8'h0b);
        set_wave(2'd0, 4'd0);
        chk(amplitude_scale[0], 6'h04, "scale default");
        chk(scale_step_tenths[0], 8'd250, "scale step");
        chk(pulse_template_select[0], 4'hb, "template");
        chk(wave_code[0], 7'h01, "sample");
        set_wave(2'd3, 4'd0);
        chk(wave_code[0], 7'h07, "sample");
        axi_rd(ad(0, IDX_SCALE));
        chk(rd, 32'h4, "scale read");
        $display("template test done");
    endtask

    task automatic t_hz();
        @(posedge aclk);
        hz_pin <= 1'b1;
        settle(4);
        chk(tx_line_pair_drive_en, 4'h0, "pin off");
        chk(tx_path_on, 4'hf, "path runs");
        @(posedge aclk);
        hz_pin <= 1'b0;
        axi_wr(ad(2, IDX_TX_CFG1), 8'h10);
        settle(2);
        chk(tx_line_pair_drive_en, 4'hb, "bit off");
        chk(tx_path_on, 4'hf, "path runs");
        axi_wr(ad(2, IDX_TX_CFG1), 8'h00);
        axi_wr(ad(3, IDX_TX_CFG0), 8'h01);
        settle(2);
        chk(tx_line_pair_drive_en, 4'h7, "power-down");
        chk(tx_path_on, 4'h7, "path off");
        axi_wr(ad(3, IDX_TX_CFG0), 8'h00);
        settle(2);
        chk(tx_line_pair_drive_en, 4'hf, "all clear");
        $display("hz test done");
    endtask

    task automatic t_clk();
        @(posedge aclk);
        mclk_stop <= 1'b1;
        settle(4);
        chk(tx_line_pair_drive_en, 4'h0, "master lost");
        @(posedge aclk);
        mclk_stop <= 1'b0;
        tclk_stop <= 4'h2;
        settle(4);
        chk(tx_line_pair_drive_en, 4'hd, "tx clock lost");
        for (int m = 1; m < 3; m++) begin
            axi_wr(ad(1, IDX_TX_CFG0), 8'(1 << m));
            settle(2);
            chk(tx_line_pair_drive_en, 4'hf, "excepted");
        end
        axi_wr(ad(1, IDX_TX_CFG0), 8'h00);
        settle(2);
        chk(tx_line_pair_drive_en, 4'hd, "exception off");
        @(posedge aclk);
        tclk_stop <= 4'h0;
        settle(4);
        chk(tx_line_pair_drive_en, 4'hf, "clocks back");
        $display("clock test done");
    endtask

    task automatic t_soft();
        axi_wr(ad(2, IDX_TX_CFG1), 8'h0b);
        axi_wr(ad(0, IDX_SOFT_RST), 8'h01);
        settle(1);
        chk(tx_line_pair_drive_en, 4'h0, "soft reset");
        axi_rd(ad(2, IDX_TX_CFG1));
        chk(rd, 32'h0, "config cleared");
        ce <= 1'b0;
        repeat (20) @(posedge aclk);
        chk(tx_line_pair_drive_en, 4'h0, "frozen");
        ce <= 1'b1;
        settle(20);
        chk(tx_line_pair_drive_en, 4'hf, "after soft reset");
        $display("soft test done");
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        {aclk, aresetn, hz_pin, mclk_stop, tclk_stop} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awprot} = '0;
        {s_axi_arprot, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, wave_ui, wave_sample} = '0;
        ce = 1'b1;
        s_axi_wstrb = 4'h1;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_term();
        t_template();
        t_hz();
        t_clk();
        t_soft();
        tally_and_finish();
    end
endmodule
